//--- design/dops_top.sv
// pwm timing, overlap, supply sequencing and bidirectional sync top
`timescale 1ns/1ns
module dops_top import dops_pkg::*; #(
  parameter int SET_W = 4 // overlap setting width
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // timing ramp comparators
  input wire logic ramp_peak_level, // ramp at 3.0 V
  input wire logic ramp_slave_peak_level, // ramp at 4.0 V
  input wire logic ramp_valley_level, // ramp down to 2.0 V
  // duty comparators
  input wire logic line_ramp_above_error, // line_ramp over error_voltage_in
  input wire logic error_voltage_in_margin, // error 0.5 V over ramp valley
  input wire logic line_ramp_at_limit, // line_ramp at 3.0 V
  input wire logic duty_limit_in, // any other duty limiter
  // supply and line supervision
  input wire logic aux_at_turn_on, // aux at or above turn-on level
  input wire logic aux_at_turn_off, // aux fallen to 7.0 V
  input wire logic line_undervoltage_fault,
  input wire logic line_overvoltage_fault,
  input wire logic soft_stop_done, // soft-stop sequence finished
  // overlap programming
  input wire logic [SET_W-1:0] overlap_setting,
  // shared sync pin
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe_n,
  // drives
  output logic main_drive_out,
  output logic clamp_drive_out,
  // oscillator and ramp controls
  output logic ramp_discharge_out, // discharge current on
  output logic slave_mode_out, // upper threshold at 4.0 V
  output logic line_ramp_reset_out, // ground line ramp capacitor
  // sequencing
  output logic startup_en_out, // startup circuit on
  output logic outputs_en_out, // drive outputs enabled
  output logic soft_start_out, // one-cycle soft-start trigger
  output logic soft_stop_out, // soft-stop in progress
  output logic reference_en_out // reference output on
);

  dops_link_if #(.SET_W(SET_W)) lnk ();

  // ==========================================================
  // state
  dops_osc_e osc_r; // oscillator phase
  dops_osc_e osc_nxt;
  dops_seq_e seq_r; // supply sequencer
  dops_seq_e seq_nxt;
  logic slave_r; // slave mode flag
  logic slave_nxt;
  logic sync_in_d_r; // pin level one cycle back
  logic aux_on_d_r; // turn-on comparator one cycle back
  logic req_r; // on-time request
  logic req_nxt;
  logic ref_r; // reference enable
  logic ref_nxt;
  logic fire_r; // own sync pulse request
  logic soft_start_r;
  logic line_reset_r;

  // ==========================================================
  // decoding
  // pulses seen only while charging and not driving our own
  wire ext_pulse = sync_pin_in && !sync_in_d_r && lnk.sync_oe_n;
  wire charging = osc_r == OSC_CHARGE;
  wire peak_hit = slave_r ? ramp_slave_peak_level : ramp_peak_level;
  wire ext_take = charging && ext_pulse;
  wire peak_take = charging && !ext_pulse && peak_hit;
  wire valley_hit = !charging && ramp_valley_level;
  wire fault_now = line_undervoltage_fault || line_overvoltage_fault;
  wire aux_rise = aux_at_turn_on && !aux_on_d_r;
  wire run_en = seq_r == SEQ_RUN;
  wire duty_end = line_ramp_above_error || line_ramp_at_limit || duty_limit_in;

  // ==========================================================
  // oscillator and sync master/slave selection
  always_comb begin
    osc_nxt = osc_r;
    slave_nxt = slave_r;
    if (ext_take) begin
      // someone else fired first: follow it
      osc_nxt = OSC_DISCHARGE;
      slave_nxt = 1'b1;
    end else if (peak_take) begin
      // own peak with no pulse: become or stay master
      osc_nxt = OSC_DISCHARGE;
      slave_nxt = 1'b0;
    end else if (valley_hit) begin
      osc_nxt = OSC_CHARGE;
    end
  end

  // ==========================================================
  // on-time request: begins at valley, ends on any limiter
  always_comb begin
    req_nxt = req_r;
    if (!run_en || osc_nxt == OSC_DISCHARGE) begin
      // peak ends the pulse; overlap makes max duty charge minus delay
      req_nxt = 1'b0;
    end else if (req_r && duty_end) begin
      req_nxt = 1'b0;
    end else if (valley_hit) begin
      // zero duty when the error sits under the margin
      req_nxt = error_voltage_in_margin && !duty_end;
    end
  end

  // ==========================================================
  // supply sequencer
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_OFF: begin
        if (aux_rise && !fault_now) begin
          seq_nxt = SEQ_RUN;
        end else if (aux_rise) begin
          seq_nxt = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        // fault must be gone and turn-on reached afresh
        if (aux_rise && !fault_now) begin
          seq_nxt = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (fault_now || aux_at_turn_off || !aux_at_turn_on) begin
          seq_nxt = SEQ_STOP;
        end
      end
      default: begin
        if (soft_stop_done) begin
          seq_nxt = SEQ_OFF;
        end
      end
    endcase
  end

  // reference: on with turn-on and no undervoltage, off after a stop under undervoltage
  always_comb begin
    ref_nxt = ref_r;
    if (aux_at_turn_on && !line_undervoltage_fault && seq_r != SEQ_STOP) begin
      ref_nxt = 1'b1;
    end else if (seq_r == SEQ_STOP && soft_stop_done && line_undervoltage_fault) begin
      ref_nxt = 1'b0;
    end
  end

  // ==========================================================
  // state flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_r <= OSC_CHARGE;
      slave_r <= 1'b0;
      seq_r <= SEQ_OFF;
      req_r <= 1'b0;
      ref_r <= 1'b0;
      sync_in_d_r <= 1'b0;
      aux_on_d_r <= 1'b0;
    end else begin
      osc_r <= osc_nxt;
      slave_r <= slave_nxt;
      seq_r <= seq_nxt;
      req_r <= req_nxt;
      ref_r <= ref_nxt;
      sync_in_d_r <= sync_pin_in;
      aux_on_d_r <= aux_at_turn_on;
    end
  end

  // event flops: sync fire, soft-start trigger, line ramp reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fire_r <= 1'b0;
      soft_start_r <= 1'b0;
      line_reset_r <= 1'b1;
    end else begin
      fire_r <= peak_take;
      soft_start_r <= seq_r != SEQ_RUN && seq_nxt == SEQ_RUN;
      line_reset_r <= !req_nxt;
    end
  end

  // registered output copies
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ramp_discharge_out <= 1'b0;
      slave_mode_out <= 1'b0;
      startup_en_out <= 1'b1;
      outputs_en_out <= 1'b0;
      soft_stop_out <= 1'b0;
    end else begin
      ramp_discharge_out <= osc_nxt == OSC_DISCHARGE;
      slave_mode_out <= slave_nxt;
      startup_en_out <= !aux_at_turn_on && seq_nxt != SEQ_RUN;
      outputs_en_out <= seq_nxt == SEQ_RUN || seq_nxt == SEQ_STOP;
      soft_stop_out <= seq_nxt == SEQ_STOP;
    end
  end

  assign soft_start_out = soft_start_r;
  assign reference_en_out = ref_r;
  assign line_ramp_reset_out = line_reset_r;
  assign lnk.drive_req = req_r;
  assign lnk.setting = overlap_setting;
  assign lnk.sync_fire = fire_r;
  assign main_drive_out = lnk.main_drive;
  assign clamp_drive_out = lnk.clamp_drive;
  assign sync_pin_out = lnk.sync_out;
  assign sync_pin_oe_n = lnk.sync_oe_n;

  // ==========================================================
  // helpers
  dops_overlap #(.SET_W(SET_W)) u_overlap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lnk(lnk.overlap)
  );

  dops_sync_pulse u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lnk(lnk.sync)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  valley_charge_a: assert property (
    osc_r == OSC_DISCHARGE && ramp_valley_level |=> osc_r == OSC_CHARGE)
    else $error("valley did not restart charge");
  slave_entry_a: assert property (
    charging && ext_pulse |=> slave_r && osc_r == OSC_DISCHARGE && !fire_r)
    else $error("external pulse not followed");
  slave_revert_a: assert property (
    charging && slave_r && !ext_pulse && ramp_slave_peak_level |=> !slave_r ##1 !sync_pin_oe_n)
    else $error("slave did not revert");
  master_pulse_a: assert property (
    charging && !slave_r && !ext_pulse && ramp_peak_level |=> ##1 sync_pin_oe_n == 1'b0)
    else $error("own sync pulse missing");
  pin_released_a: assert property (
    charging && !fire_r && $past(sync_pin_oe_n) |-> sync_pin_oe_n)
    else $error("pin driven while charging");
  no_drive_off_a: assert property (
    seq_r == SEQ_OFF || seq_r == SEQ_WAIT |-> ##2 !clamp_drive_out)
    else $error("drives active while disabled");
  fault_hold_a: assert property (
    seq_r == SEQ_OFF && aux_rise && fault_now |=> seq_r == SEQ_WAIT)
    else $error("fault at turn-on not held");
  duty_end_a: assert property (
    req_r && duty_end |=> !req_r ##1 !main_drive_out)
    else $error("duty limit did not end pulse");
  zero_duty_a: assert property (
    valley_hit && !error_voltage_in_margin |=> !req_r)
    else $error("pulse issued under margin");
  stop_on_fault_a: assert property (
    seq_r == SEQ_RUN && line_overvoltage_fault |=> seq_r == SEQ_STOP ##0 soft_stop_out)
    else $error("line fault did not stop");
  ref_off_a: assert property (
    seq_r == SEQ_STOP && soft_stop_done && line_undervoltage_fault |=> !reference_en_out)
    else $error("reference kept after stop");

  slave_seen_c: cover property (ext_take ##[1:200] slave_r && peak_take);
  main_pulse_c: cover property ($rose(main_drive_out) ##[1:300] $fell(clamp_drive_out));
  wait_seen_c: cover property (seq_r == SEQ_WAIT ##[1:50] seq_r == SEQ_RUN);
  stop_seen_c: cover property (seq_r == SEQ_STOP ##[1:50] seq_r == SEQ_OFF);
endmodule

//--- design/dops_pkg.sv
// constants, encodings and timing figures for the dual output pwm sync block
// What this block does
// - ramp above error ends the drive pulse
// - no pulses unless error clears valley margin
// - main and clamp drives switch in phase
// - turn-on level enables outputs, disables startup
// - fault at turn-on holds outputs off, rearm
// - soft-stop then disable on low supply
// - clamp rises first and falls last
// - overlap scales with setting, minimum 20 ns lead, 12 ns trail
// - leading overlap longer than trailing overlap
// - discharge at peak, charge at valley
// - valley raises clamp, peak drops main
// - max duty is charge minus overlap
// - pin released while charging, pulses accepted
// - no pulse by peak: drive 100 ns
// - external pulse: slave, discharge, 4 V threshold
// - slave without pulse by 4 V: master
// - first pulse emitter is master, others slaves
// - follows sync faster or slower than own
// - reference on at turn-on without undervoltage
// - reference off after soft-stop if undervoltage
// - line faults after enable start soft-stop
// - line ramp limit or duty limit ends pulse
package dops_pkg;

  // ==========================================================
  // clock and timing figures
  localparam int CLK_PERIOD_NS = 4; // core clock period
  localparam int SYNC_PULSE_NS = 100; // own sync pulse width
  localparam int OVL_LEAD_MIN_NS = 20; // leading overlap at minimum setting
  localparam int OVL_TRAIL_MIN_NS = 12; // trailing overlap at minimum setting
  // exact division for the pulse, round up for the least delays
  localparam int SYNC_PULSE_CYC = SYNC_PULSE_NS / CLK_PERIOD_NS;
  localparam int OVL_LEAD_CYC = (OVL_LEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVL_TRAIL_CYC = (OVL_TRAIL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVL_CNT_W = 8; // overlap counter width
  localparam int SYNC_CNT_W = 5; // sync pulse counter width

  // ==========================================================
  // reset values
  localparam logic RST_DRIVE = 1'b0; // drives low in reset
  localparam logic RST_PIN_OE_N = 1'b1; // sync pin released in reset

  // ==========================================================
  // state encodings
  typedef enum logic {
    OSC_CHARGE = 1'b0,
    OSC_DISCHARGE = 1'b1
  } dops_osc_e;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_RUN = 2'b10,
    SEQ_STOP = 2'b11
  } dops_seq_e;

endpackage

//--- design/dops_link_if.sv
// interface between the top and its overlap and sync pulse helpers
`timescale 1ns/1ns
interface dops_link_if #(parameter int SET_W = 4);
  logic drive_req; // wanted on-time, before overlap
  logic [SET_W-1:0] setting; // overlap programming value
  logic main_drive; // main drive after overlap
  logic clamp_drive; // clamp drive after overlap
  logic sync_fire; // one-cycle request for own sync pulse
  logic sync_out; // level driven on the sync pin
  logic sync_oe_n; // low while the pin is driven

  modport top (output drive_req, setting, sync_fire,
               input main_drive, clamp_drive, sync_out, sync_oe_n);
  modport overlap (input drive_req, setting, output main_drive, clamp_drive);
  modport sync (input sync_fire, output sync_out, sync_oe_n);
endinterface

//--- design/dops_overlap.sv
// overlap delay generator for the main and clamp drives
`timescale 1ns/1ns
module dops_overlap import dops_pkg::*; #(
  parameter int SET_W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link to the top
  dops_link_if.overlap lnk
);

  // ==========================================================
  // elaboration check: longest lead must fit the counter
  if ((2 ** SET_W) * OVL_LEAD_CYC > 2 ** OVL_CNT_W - 1) begin : g_chk
    $error("overlap setting width too large for counter");
  end

  logic req_d_r; // request one cycle back
  logic main_r; // main drive flop
  logic clamp_r; // clamp drive flop
  logic [OVL_CNT_W-1:0] cnt_r; // overlap countdown
  logic [OVL_CNT_W-1:0] cnt_nxt;
  logic main_nxt;
  logic clamp_nxt;

  // delays scale with setting+1; lead base exceeds trail base
  wire [OVL_CNT_W-1:0] set_ext = OVL_CNT_W'(lnk.setting) + 8'h01;
  wire [OVL_CNT_W-1:0] lead_cyc = OVL_CNT_W'(set_ext * OVL_CNT_W'(OVL_LEAD_CYC));
  wire [OVL_CNT_W-1:0] trail_cyc = OVL_CNT_W'(set_ext * OVL_CNT_W'(OVL_TRAIL_CYC));
  wire req_edge = lnk.drive_req != req_d_r;
  wire done = (cnt_r == 8'h00) && !req_edge;

  // ==========================================================
  // next values: clamp leads on rise, main leads on fall
  always_comb begin
    clamp_nxt = lnk.drive_req | (clamp_r & !done);
    main_nxt = lnk.drive_req & (main_r | done);
    if (req_edge) begin
      // reload on every edge of the request
      cnt_nxt = lnk.drive_req ? lead_cyc - 8'h01 : trail_cyc - 8'h01;
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // drive flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_d_r <= 1'b0;
      main_r <= RST_DRIVE;
      clamp_r <= RST_DRIVE;
      cnt_r <= 8'h00;
    end else begin
      req_d_r <= lnk.drive_req;
      main_r <= main_nxt;
      clamp_r <= clamp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign lnk.main_drive = main_r;
  assign lnk.clamp_drive = clamp_r;

  // ==========================================================
  // checks
  main_inside_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    main_r |-> clamp_r) else $error("main high without clamp");
  lead_min_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(clamp_r) && lnk.setting == '0 |-> !main_r[*5] ##1 (main_r || !lnk.drive_req))
    else $error("leading overlap wrong");
  trail_min_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(main_r) && lnk.setting == '0 |-> clamp_r[*3] ##1 (!clamp_r || lnk.drive_req))
    else $error("trailing overlap wrong");
endmodule

//--- design/dops_sync_pulse.sv
// fixed-width pulse driver for the shared sync pin
`timescale 1ns/1ns
module dops_sync_pulse import dops_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link to the top
  dops_link_if.sync lnk
);

  logic [SYNC_CNT_W-1:0] cnt_r; // cycles left in own pulse
  logic oe_n_r; // pin enable, low while driving
  logic out_r; // pin level

  // pulse counter; a fire while busy is ignored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      oe_n_r <= RST_PIN_OE_N;
      out_r <= 1'b0;
    end else if (lnk.sync_fire && oe_n_r) begin
      cnt_r <= SYNC_CNT_W'(SYNC_PULSE_CYC - 1);
      oe_n_r <= 1'b0;
      out_r <= 1'b1;
    end else if (!oe_n_r && cnt_r == 5'h00) begin
      // timer expired: release the pin
      oe_n_r <= 1'b1;
      out_r <= 1'b0;
    end else if (!oe_n_r) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  assign lnk.sync_out = out_r;
  assign lnk.sync_oe_n = oe_n_r;

  // ==========================================================
  // checks
  pulse_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(oe_n_r) |-> (!oe_n_r)[*8] ##17 !oe_n_r ##1 oe_n_r)
    else $error("sync pulse not 25 cycles");
endmodule

//--- sim/dops_far_model.sv
// far side model: timing ramp capacitor, pulled-down sync wire and a peer controller
`timescale 1ns/1ns
module dops_far_model #(
  parameter int PK = 120, // ramp steps from valley to 3.0 V
  parameter int CS = 3, // charge steps a cycle
  parameter int DS = 4, // discharge steps a cycle
  parameter int PW = 25 // peer sync pulse width in cycles
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ramp control and comparators
  input wire logic discharge,
  output logic peak,
  output logic slave_peak,
  output logic valley,
  // shared sync wire
  input wire logic dut_out,
  input wire logic dut_oe_n,
  input wire logic peer_en,
  input wire logic [7:0] peer_period,
  output logic wire_lvl
);
  // ==========================================================
  // ramp and peer state
  int r_r; // ramp height in steps above the valley
  int pc_r; // peer phase counter
  logic peer_drv; // peer pulling the wire high
  // 4.0 V sits twice as far above the valley as 3.0 V
  assign peak = r_r >= PK;
  assign slave_peak = r_r >= 2 * PK;
  assign valley = r_r == 0;
  // the bench keeps the peer period below the slave charge time
  assign peer_drv = peer_en && pc_r < PW;
  // resistor pulldown: nobody driving means a low wire, never the last value
  assign wire_lvl = (!dut_oe_n && dut_out) || peer_drv;
  // ==========================================================
  // capacitor and peer oscillator
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r_r <= 0;
      pc_r <= 0;
    end else begin
      // capped so a stuck charge phase cannot overflow
      if (discharge) r_r <= (r_r > DS) ? r_r - DS : 0;
      else if (r_r < 3 * PK) r_r <= r_r + CS;
      if (!peer_en) pc_r <= 0;
      else pc_r <= (pc_r >= int'(peer_period) - 1) ? 0 : pc_r + 1;
    end
  end
endmodule

//--- sim/dual_output_pwm_sync_tb.sv
// self-checking bench for pwm timing, overlap, sequencing and sync
`timescale 1ns/1ns
module dual_output_pwm_sync_tb import dops_pkg::*; ;
  // ==========================================================
  // stimulus and observed signals
  localparam int CHG = 40; // model charge cycles valley to peak
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] lim = 4'h0; // duty limiters, bit 3 means margin lost
  logic aux = 1'b0, aux_off = 1'b0, uv = 1'b0, ov = 1'b0, done = 1'b0;
  logic [3:0] setting = 4'h8; // lead of 45 cycles, beyond the 40-cycle charge time
  logic peer_en = 1'b0;
  logic [7:0] peer_period = 8'h1e;
  logic peak, speak, valley, sync_in, sync_out, oe_n, main, clamp, disch, slave;
  logic lrr, startup, oen, ss, sstop, ref_en;
  int n_errors = 0;
  int cmp_count = 0;

  initial forever #2 core_clk = ~core_clk;

  dops_top #(.SET_W(4)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ramp_peak_level(peak),
    .ramp_slave_peak_level(speak), .ramp_valley_level(valley),
    .line_ramp_above_error(lim[0]), .error_voltage_in_margin(!lim[3]),
    .line_ramp_at_limit(lim[1]), .duty_limit_in(lim[2]), .aux_at_turn_on(aux),
    .aux_at_turn_off(aux_off), .line_undervoltage_fault(uv),
    .line_overvoltage_fault(ov), .soft_stop_done(done), .overlap_setting(setting),
    .sync_pin_in(sync_in), .sync_pin_out(sync_out), .sync_pin_oe_n(oe_n),
    .main_drive_out(main), .clamp_drive_out(clamp), .ramp_discharge_out(disch),
    .slave_mode_out(slave), .line_ramp_reset_out(lrr), .startup_en_out(startup),
    .outputs_en_out(oen), .soft_start_out(ss), .soft_stop_out(sstop),
    .reference_en_out(ref_en));

  dops_far_model u_far (
    .core_clk(core_clk), .rst_n(rst_n), .discharge(disch), .peak(peak),
    .slave_peak(speak), .valley(valley), .dut_out(sync_out), .dut_oe_n(oe_n),
    .peer_en(peer_en), .peer_period(peer_period), .wire_lvl(sync_in));

  // ==========================================================
  // shared helpers
  function automatic logic sig(input int sel);
    case (sel)
      0: return main;
      1: return clamp;
      2: return oe_n;
      3: return slave;
      4: return oen;
      5: return disch;
      default: return sstop;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // waits at falling edges; a hang counts as a mismatch and ends the run
  task automatic wait_sel(input int sel, input logic val, output int cnt);
    cnt = 0;
    while (sig(sel) !== val) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 1000) begin
        check(sel, 32'hffff);
        conclude();
      end
    end
  endtask

  task automatic count_sel(input int sel, input logic val, input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (sig(sel) === val) hits++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic reset_values();
    @(negedge core_clk);
    check({main, clamp, oe_n, sync_out, disch, slave, lrr, startup, oen, ss, sstop, ref_en},
      12'h230);
  endtask

  task automatic power_up();
    int c;
    @(posedge core_clk) aux <= 1'b1;
    @(negedge core_clk);
    wait_sel(4, 1'b1, c);
    check(c, 1);
    check({ss, ref_en, startup}, 3'h6);
    @(negedge core_clk);
    check(ss, 1'b0);
  endtask

  // lead overlap longer than the charge time leaves no main pulse at all
  task automatic max_overlap();
    int h;
    count_sel(0, 1'b1, 200, h);
    check(h, 0);
    count_sel(1, 1'b1, 200, h);
    check(h != 0, 1'b1);
  endtask

  task automatic drive_timing(input logic [3:0] s);
    int l, h, t, u;
    @(posedge core_clk) setting <= s;
    @(negedge core_clk);
    wait_sel(1, 1'b0, l);
    wait_sel(1, 1'b1, l);
    wait_sel(0, 1'b1, l);
    check(l, OVL_LEAD_CYC * (s + 1));
    check(lrr, 1'b0);
    wait_sel(0, 1'b0, h);
    check(h, CHG + 1 - l);
    check({oe_n, sync_out, lrr}, 3'h3);
    wait_sel(1, 1'b0, t);
    check(t, OVL_TRAIL_CYC * (s + 1));
    wait_sel(2, 1'b1, u);
    check(t + u, SYNC_PULSE_CYC);
  endtask

  task automatic limiters();
    int c;
    for (int i = 0; i < 4; i++) begin
      wait_sel(0, 1'b1, c);
      @(posedge core_clk) lim <= 4'h1 << i;
      @(negedge core_clk);
      wait_sel(0, 1'b0, c);
      if (i < 3) check(c, 2);
      count_sel(0, 1'b1, 150, c);
      check(c, 0);
      @(posedge core_clk) lim <= 4'h0;
    end
  endtask

  task automatic sync_follow(input logic [7:0] p);
    int a, b;
    @(posedge core_clk);
    peer_period <= p;
    peer_en <= 1'b1;
    repeat (400) @(negedge core_clk);
    check(slave, 1'b1);
    count_sel(2, 1'b0, 2 * p, a);
    check(a, 0);
    wait_sel(5, 1'b0, a);
    wait_sel(5, 1'b1, a);
    wait_sel(5, 1'b0, a);
    wait_sel(5, 1'b1, b);
    check(a + b, p);
  endtask

  task automatic sync_revert();
    int c;
    @(posedge core_clk) peer_en <= 1'b0;
    @(negedge core_clk);
    wait_sel(3, 1'b0, c);
    check(disch, 1'b1);
    wait_sel(2, 1'b0, c);
    check(c, 1);
  endtask

  // f holds aux below turn-on, aux at 7.0 V, undervoltage, overvoltage
  task automatic stop_case(input logic [3:0] f, input logic clr);
    int c;
    @(posedge core_clk);
    {aux_off, uv, ov} <= f[2:0];
    aux <= !f[3];
    @(negedge core_clk);
    wait_sel(6, 1'b1, c);
    check(c, 1);
    check(oen, 1'b1);
    if (clr) @(posedge core_clk) uv <= 1'b0;
    // soft-stop takes a while, so the trailing overlap ends before it does
    repeat (16) @(posedge core_clk);
    done <= 1'b1;
    @(negedge core_clk);
    wait_sel(4, 1'b0, c);
    check(c, 1);
    @(posedge core_clk) done <= 1'b0;
    check(ref_en, !(f[1] && !clr));
  endtask

  task automatic rearm(input logic with_fault);
    int c;
    if (with_fault) begin
      @(posedge core_clk) aux <= 1'b0;
      @(posedge core_clk);
      aux <= 1'b1;
      ov <= 1'b1;
      count_sel(4, 1'b1, 40, c);
      check(c, 0);
      @(posedge core_clk) ov <= 1'b0;
      count_sel(4, 1'b1, 40, c);
      check(c, 0);
    end
    @(posedge core_clk);
    {aux_off, uv, ov} <= 3'h0;
    aux <= 1'b0;
    @(posedge core_clk) aux <= 1'b1;
    @(negedge core_clk);
    wait_sel(4, 1'b1, c);
    check(c, 1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_values();
    repeat (7) @(posedge core_clk);
    rst_n <= 1'b1;
    power_up();
    max_overlap();
    drive_timing(4'h0);
    drive_timing(4'h2);
    limiters();
    sync_follow(8'h1e);
    sync_follow(8'h4e);
    sync_revert();
    stop_case(4'h1, 1'b0);
    rearm(1'b1);
    stop_case(4'h2, 1'b0);
    rearm(1'b0);
    stop_case(4'h2, 1'b1);
    rearm(1'b0);
    stop_case(4'h4, 1'b0);
    rearm(1'b0);
    stop_case(4'h8, 1'b0);
    conclude();
  end
endmodule
